/* asrc_cfg.svh */
`ifndef ASRC_CFG_SVH
`define ASRC_CFG_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define ASRC_IDX_FLAGS     8'h0C
`define ASRC_IDX_RES_HIGH  8'h1E
`define ASRC_IDX_CONTROL   8'h1F
`define ASRC_IDX_ENABLES   8'h8C
`define ASRC_IDX_RES_LOW   8'h9E
`define ASRC_IDX_ANA_SEL   8'h9F

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ASRC_CTL_JUSTIFY   7
`define ASRC_CTL_REF       6
`define ASRC_CTL_CHAN_LO   2
`define ASRC_CTL_GO        1
`define ASRC_CTL_ON        0
`define ASRC_ANS_CLK_LO    4
`define ASRC_IRQ_DONE_BIT  6

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define ASRC_RST_CTL_BYTE  8'h00
`define ASRC_RST_ANA_SEL   8'h0F
`define ASRC_RST_ENABLES   8'h00

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ASRC_CLK_MHZ       50
`define ASRC_INSTR_CYC     4
`define ASRC_CONV_TADS     11
`define ASRC_POST_TADS     2
`define ASRC_RC_TAD_NS     2000
`define ASRC_RC_TAD_CYC    ((`ASRC_RC_TAD_NS * `ASRC_CLK_MHZ + 999) / 1000)

`endif

/* asrc_pkg.sv */
package asrc_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DELAY,
		ST_CONV,
		ST_POST
	} asrc_state_t;

	typedef logic [2:0] asrc_clksel_t;
endpackage

/* asrc_tad_if.sv */
interface asrc_tad_if;
	import asrc_pkg::*;
	logic         run;
	asrc_clksel_t sel;
	logic         tick;
	logic         isRc;

	modport gen (input run, input sel, output tick, output isRc);
	modport user (output run, output sel, input tick, input isRc);
endinterface

/* asrc_tad_gen.sv */
`include "asrc_cfg.svh"

module asrc_tad_gen import asrc_pkg::*; #(
	parameter int RC_TAD_CYC = `ASRC_RC_TAD_CYC
) (
	input  wire logic clock,
	input  wire logic nrst,
	asrc_tad_if.gen   tad
);
	// ---------------------------------------------------------------
	// Divider decode
	// ---------------------------------------------------------------
	logic [7:0] divLen;
	logic [7:0] cnt_r;

	assign tad.isRc = (tad.sel[1:0] == 2'b11);

	always_comb begin
		unique case (tad.sel) // see RULE_15
			3'b000: divLen = 8'h02;
			3'b100: divLen = 8'h04;
			3'b001: divLen = 8'h08;
			3'b101: divLen = 8'h10;
			3'b010: divLen = 8'h20;
			3'b110: divLen = 8'h40;
			default: divLen = 8'(RC_TAD_CYC);
		endcase
	end

	// ---------------------------------------------------------------
	// Period counter, held in reset while idle so each run starts clean
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_r    <= 8'h00;
			tad.tick <= 1'b0;
		end else if (!tad.run) begin
			cnt_r    <= 8'h00;
			tad.tick <= 1'b0;
		end else if (cnt_r == divLen - 8'h01) begin // see RULE_14
			cnt_r    <= 8'h00;
			tad.tick <= 1'b1;
		end else begin
			cnt_r    <= cnt_r + 8'h01;
			tad.tick <= 1'b0;
		end
	end

	a_tick_div_two: assert property (@(posedge clock) disable iff (!nrst) // see RULE_15
		(tad.tick && tad.run && tad.sel == 3'b000 && $stable(tad.sel)) |=> !tad.tick ##1 (tad.tick || !tad.run))
		else $error("divide-by-two period wrong");
endmodule

/* asrc_adc_ctrl.sv */
// What this block does
// RULE_01 - After a conversion the holding capacitor stays off the input for two conversion clock periods.
// RULE_02 - The holding capacitor is never discharged at the end of a conversion.
// RULE_03 - Software allows settling plus charge time, plus a term above 25 C, before starting.
// RULE_04 - A conversion can finish during sleep only with the dedicated RC clock selected.
// RULE_05 - With the RC clock a requested conversion starts one instruction cycle later.
// RULE_06 - On completion the in-progress bit clears and both result registers load.
// RULE_07 - A completion in sleep with the interrupt enabled raises a wake request.
// RULE_08 - A completion in sleep with the interrupt disabled powers the module down, on bit kept.
// RULE_09 - Sleep with a non-RC clock aborts any conversion and powers down, on bit kept.
// RULE_10 - Reset restores all control registers, powers down and aborts any conversion.
// RULE_11 - Reset leaves both result registers unchanged.
// RULE_12 - Left format puts two low bits in the low register, right format puts eight there.
// RULE_13 - Setting the in-progress bit starts a conversion; completion clears it and sets flag bit 6.
// RULE_14 - A conversion takes eleven conversion clock periods from a selectable source.
// RULE_15 - Clock select decodes 000/2, 100/4, 001/8, 101/16, 010/32, 110/64, x11 RC.
// RULE_16 - The block takes a sleep input and drives a wake request and a flag set pulse.
`include "asrc_cfg.svh"

module asrc_adc_ctrl import asrc_pkg::*; #(
	parameter int RC_TAD_CYC = `ASRC_RC_TAD_CYC,
	parameter int CONV_TADS  = `ASRC_CONV_TADS,
	parameter int POST_TADS  = `ASRC_POST_TADS,
	parameter int INSTR_CYC  = `ASRC_INSTR_CYC
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sleepIn,
	input  wire logic [9:0]  convData,
	output logic             irq,
	output logic             wakeReq,
	output logic             doneFlagSet,
	output logic             modulePowered,
	output logic             holdConnected,
	output logic      [1:0]  channelSelect,
	output logic             referenceSelect,
	output logic      [3:0]  analogPinSelect
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	asrc_state_t  state_r;
	logic [3:0]   cnt_r;
	logic         justifySelect_r;
	logic         go_r;
	logic         converterOn_r;
	asrc_clksel_t convClockSelect_r;
	logic         doneFlag_r;
	logic         doneEnable_r;
	logic         sleepOff_r;
	logic [7:0]   resultHigh_r;
	logic [7:0]   resultLow_r;
	logic         powered;
	logic         convDone;
	logic         sleepAbort;
	logic         swAbort;

	asrc_tad_if tadBus ();

	asrc_tad_gen #(
		.RC_TAD_CYC (RC_TAD_CYC)
	) u_tad (
		.clock (clock),
		.nrst  (nrst),
		.tad   (tadBus)
	);

	assign tadBus.sel = convClockSelect_r;
	assign tadBus.run = (state_r == ST_CONV) || (state_r == ST_POST);

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	logic [7:0] wordIdx;
	logic       mapped;
	logic       access;
	logic       wrEn;
	logic       rdEn;
	logic [7:0] rdVal;

	assign wordIdx = paddr[9:2];
	assign access  = psel && penable && pready;
	assign wrEn    = access && pwrite && !pslverr;
	assign rdEn    = access && !pwrite && !pslverr;

	always_comb begin
		mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
		rdVal  = 8'h00;
		unique case (wordIdx)
			`ASRC_IDX_FLAGS:    rdVal[`ASRC_IRQ_DONE_BIT] = doneFlag_r;
			`ASRC_IDX_ENABLES:  rdVal[`ASRC_IRQ_DONE_BIT] = doneEnable_r;
			`ASRC_IDX_RES_HIGH: rdVal = resultHigh_r;
			`ASRC_IDX_RES_LOW:  rdVal = resultLow_r;
			`ASRC_IDX_CONTROL:  rdVal = {justifySelect_r, referenceSelect, 2'b00,
				channelSelect, go_r, converterOn_r};
			`ASRC_IDX_ANA_SEL:  rdVal = {1'b0, convClockSelect_r, analogPinSelect};
			default:            mapped = 1'b0;
		endcase
	end

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= !mapped;
			prdata  <= mapped ? {24'h00_0000, rdVal} : 32'h0000_0000;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	logic ctlWr;
	logic ansWr;

	assign ctlWr = wrEn && (wordIdx == `ASRC_IDX_CONTROL);
	assign ansWr = wrEn && (wordIdx == `ASRC_IDX_ANA_SEL);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin // see RULE_10
			justifySelect_r <= 1'(`ASRC_RST_CTL_BYTE >> `ASRC_CTL_JUSTIFY);
			referenceSelect <= 1'b0;
			channelSelect   <= 2'b00;
			converterOn_r   <= 1'b0;
		end else if (ctlWr) begin
			justifySelect_r <= pwdata[`ASRC_CTL_JUSTIFY];
			referenceSelect <= pwdata[`ASRC_CTL_REF];
			channelSelect   <= pwdata[`ASRC_CTL_CHAN_LO +: 2];
			converterOn_r   <= pwdata[`ASRC_CTL_ON];
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			convClockSelect_r <= 3'(`ASRC_RST_ANA_SEL >> `ASRC_ANS_CLK_LO);
			analogPinSelect   <= 4'(`ASRC_RST_ANA_SEL);
		end else if (ansWr) begin
			convClockSelect_r <= pwdata[`ASRC_ANS_CLK_LO +: 3];
			analogPinSelect   <= pwdata[3:0];
		end
	end

	// Hardware clear comes last so completion always wins over a write
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			go_r <= 1'b0;
		end else begin
			if (ctlWr) begin
				go_r <= pwdata[`ASRC_CTL_GO]; // see RULE_13
			end
			if (convDone || sleepAbort) begin
				go_r <= 1'b0; // see RULE_06
			end
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	assign powered    = converterOn_r && !sleepOff_r;
	assign sleepAbort = sleepIn && !tadBus.isRc && (state_r == ST_DELAY || state_r == ST_CONV); // see RULE_09
	assign swAbort    = !go_r && (state_r == ST_DELAY || state_r == ST_CONV);
	assign convDone   = (state_r == ST_CONV) && tadBus.tick && go_r && !sleepAbort && converterOn_r
		&& (cnt_r == 4'(CONV_TADS - 1)); // see RULE_14

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE; // see RULE_10
			cnt_r   <= 4'h0;
		end else if (sleepAbort || !converterOn_r) begin
			state_r <= ST_IDLE;
			cnt_r   <= 4'h0;
		end else if (swAbort) begin
			state_r <= ST_POST; // aborted sample still needs the gap
			cnt_r   <= 4'h0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					cnt_r <= 4'h0;
					if (go_r && powered) begin
						// Lets a sleep instruction land before the quiet conversion
						state_r <= tadBus.isRc ? ST_DELAY : ST_CONV; // see RULE_05
					end
				end
				ST_DELAY: begin
					if (cnt_r == 4'(INSTR_CYC - 1)) begin // see RULE_05
						state_r <= ST_CONV;
						cnt_r   <= 4'h0;
					end else begin
						cnt_r <= cnt_r + 4'h1;
					end
				end
				ST_CONV: begin
					if (convDone) begin
						state_r <= ST_POST;
						cnt_r   <= 4'h0;
					end else if (tadBus.tick) begin
						cnt_r <= cnt_r + 4'h1;
					end
				end
				ST_POST: begin
					if (tadBus.tick && cnt_r == 4'(POST_TADS - 1)) begin // see RULE_01
						state_r <= ST_IDLE;
						cnt_r   <= 4'h0;
					end else if (tadBus.tick) begin
						cnt_r <= cnt_r + 4'h1;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Power and sampling switch
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sleepOff_r <= 1'b0;
		end else if (!sleepIn) begin
			sleepOff_r <= 1'b0;
		end else if (!tadBus.isRc) begin
			sleepOff_r <= 1'b1; // see RULE_09
		end else if (convDone && !doneEnable_r) begin
			sleepOff_r <= 1'b1; // see RULE_08
		end
	end

	// Switch open during conversion and gap; no discharge path exists
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			holdConnected <= 1'b0;
			modulePowered <= 1'b0;
		end else begin
			holdConnected <= powered && (state_r == ST_IDLE || state_r == ST_DELAY); // see RULE_01, see RULE_02
			modulePowered <= powered; // see RULE_04
		end
	end

	// ---------------------------------------------------------------
	// Result registers, outside reset on purpose
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin // see RULE_11
		if (convDone) begin
			if (justifySelect_r) begin // see RULE_12
				resultHigh_r <= {6'h00, convData[9:8]};
				resultLow_r  <= convData[7:0];
			end else begin
				resultHigh_r <= convData[9:2];
				resultLow_r  <= {convData[1:0], 6'h00};
			end
		end else begin
			if (wrEn && wordIdx == `ASRC_IDX_RES_HIGH) begin
				resultHigh_r <= pwdata[7:0];
			end
			if (wrEn && wordIdx == `ASRC_IDX_RES_LOW) begin
				resultLow_r <= pwdata[7:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Interrupt flag, mask and wake
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			doneFlag_r <= 1'b0;
		end else if (convDone) begin
			doneFlag_r <= 1'b1; // see RULE_13
		end else if (rdEn && wordIdx == `ASRC_IDX_FLAGS && prdata[`ASRC_IRQ_DONE_BIT]) begin
			// Clears only a flag the read reported, so a later set is not lost
			doneFlag_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			doneEnable_r <= 1'(`ASRC_RST_ENABLES >> `ASRC_IRQ_DONE_BIT);
		end else if (wrEn && wordIdx == `ASRC_IDX_ENABLES) begin
			doneEnable_r <= pwdata[`ASRC_IRQ_DONE_BIT];
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irq         <= 1'b0;
			wakeReq     <= 1'b0;
			doneFlagSet <= 1'b0;
		end else begin
			irq         <= (doneFlag_r || convDone) && doneEnable_r;
			wakeReq     <= convDone && sleepIn && doneEnable_r; // see RULE_07, see RULE_16
			doneFlagSet <= convDone; // see RULE_16
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_post_hold_open: assert property (@(posedge clock) disable iff (!nrst) // see RULE_01
		(state_r == ST_POST) |=> !holdConnected)
		else $error("holding capacitor connected during post gap");

	a_done_clears_go: assert property (@(posedge clock) disable iff (!nrst) // see RULE_06
		convDone |=> !go_r && doneFlag_r && state_r == ST_POST)
		else $error("completion did not clear go or set flag");

	a_result_right_fmt: assert property (@(posedge clock) disable iff (!nrst) // see RULE_12
		(convDone && justifySelect_r) |=> resultLow_r == $past(convData[7:0])
		&& resultHigh_r == {6'h00, $past(convData[9:8])})
		else $error("right justified result misplaced");

	a_rc_start_delay: assert property (@(posedge clock) disable iff (!nrst) // see RULE_05
		(state_r == ST_IDLE && go_r && powered && tadBus.isRc && !sleepAbort && converterOn_r)
		|=> state_r == ST_DELAY)
		else $error("RC start not delayed");

	a_sleep_abort_off: assert property (@(posedge clock) disable iff (!nrst) // see RULE_09
		(sleepAbort && !ctlWr) |=> state_r == ST_IDLE && converterOn_r ##1 !modulePowered)
		else $error("sleep abort did not power down");

	a_wake_on_done: assert property (@(posedge clock) disable iff (!nrst) // see RULE_07
		(convDone && sleepIn && doneEnable_r) |=> wakeReq && irq)
		else $error("no wake request after sleep completion");

	a_sleep_done_off: assert property (@(posedge clock) disable iff (!nrst) // see RULE_08
		(convDone && sleepIn && !doneEnable_r && !ctlWr) ##1 sleepIn |=> !modulePowered && converterOn_r)
		else $error("module stayed powered after silent completion");
endmodule

/* asrc_conv_model.sv */
module asrc_conv_model (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       holdConnected,
	input  wire logic       modulePowered,
	input  wire logic [9:0] analogIn,
	output logic      [9:0] convData
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [9:0] held_r;
	logic       tog_r;

	// ------------------------------------------------------------
	// Holding capacitor
	// ------------------------------------------------------------
	// Charge is never cleared, only replaced while tracking
	always_ff @(posedge clock) begin
		if (holdConnected) begin
			held_r <= analogIn;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tog_r <= 1'b0;
		end else begin
			tog_r <= ~tog_r;
		end
	end

	// Powered off: the sample is not valid, so show a moving pattern
	assign convData = modulePowered ? held_r : held_r ^ {10{tog_r}};
endmodule

/* tb_adc_sleep_reset_control.sv */
module tb_adc_sleep_reset_control;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int   RCT   = 4;
	localparam logic [11:0] A_FLG = 12'h030;
	localparam logic [11:0] A_RH  = 12'h078;
	localparam logic [11:0] A_CTL = 12'h07C;
	localparam logic [11:0] A_EN  = 12'h230;
	localparam logic [11:0] A_RL  = 12'h278;
	localparam logic [11:0] A_ANS = 12'h27C;

	logic        clock, nrst, psel, penable, pwrite, pready, pslverr, sleepIn;
	logic        irq, wakeReq, doneFlagSet, modulePowered, holdConnected, referenceSelect;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [9:0]  convData, analogIn;
	logic [1:0]  channelSelect;
	logic [3:0]  analogPinSelect;
	logic [15:0] lastRes;
	int          numErrors, nTests;

	asrc_adc_ctrl #(.RC_TAD_CYC(RCT)) dut_u (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleepIn(sleepIn), .convData(convData), .irq(irq), .wakeReq(wakeReq),
		.doneFlagSet(doneFlagSet), .modulePowered(modulePowered), .holdConnected(holdConnected),
		.channelSelect(channelSelect), .referenceSelect(referenceSelect),
		.analogPinSelect(analogPinSelect));

	asrc_conv_model conv_u (.clock(clock), .nrst(nrst), .holdConnected(holdConnected),
		.modulePowered(modulePowered), .analogIn(analogIn), .convData(convData));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic endOfTest();
		$display("comparisons %0d mismatches %0d", nTests, numErrors);
		if (numErrors == 0 && nTests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			numErrors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, exp);
	endtask

	task automatic waitHold();
		while (holdConnected !== 1'b1) begin
			@(posedge clock);
		end
		repeat (8) @(posedge clock);
	endtask

	function automatic int expTad(input logic [2:0] s);
		case (s)
			3'b000: return 2;
			3'b100: return 4;
			3'b001: return 8;
			3'b101: return 16;
			3'b010: return 32;
			3'b110: return 64;
			default: return RCT;
		endcase
	endfunction

	function automatic logic [15:0] fmt(input logic [9:0] d, input logic j);
		return j ? {6'h00, d} : {d, 6'h00};
	endfunction

	// ------------------------------------------------------------
	// One conversion, optionally with the core asleep
	// ------------------------------------------------------------
	task automatic convert(input logic [2:0] sel, input logic en, input logic slp);
		logic       just;
		logic       rf;
		logic [1:0] ch;
		logic [3:0] pins;
		int         cnt;
		int         lo;
		int         tad;
		just = 1'($urandom);
		rf = 1'($urandom);
		ch = 2'($urandom);
		pins = 4'($urandom);
		analogIn <= 10'($urandom);
		wr(A_ANS, {25'h0, sel, pins});
		wr(A_EN, {25'h0, en, 6'h00});
		wr(A_CTL, {24'h0, just, rf, 2'b00, ch, 2'b01});
		waitHold();
		wr(A_CTL, {24'h0, just, rf, 2'b00, ch, 2'b11});
		if (slp) begin
			sleepIn <= 1'b1;
		end
		tad = expTad(sel);
		lo = 11 * tad + (sel[1:0] == 2'b11 ? 4 : 0);
		cnt = 0;
		while (doneFlagSet !== 1'b1 && cnt < 2000) begin
			@(posedge clock);
			cnt++;
		end
		chk(32'(cnt >= lo && cnt <= lo + tad + 4), 32'h1);
		chk(32'(wakeReq), 32'(slp & en));
		chk(32'(irq), 32'(en));
		chk(32'(holdConnected), 32'h0);
		chk({25'h0, channelSelect, referenceSelect, analogPinSelect}, {25'h0, ch, rf, pins});
		repeat (3) @(posedge clock);
		if (slp) begin
			if (!en) begin
				chk(32'(modulePowered), 32'h0);
			end
			sleepIn <= 1'b0;
		end
		rdChk(A_CTL, {24'h0, just, rf, 2'b00, ch, 2'b01});
		rdChk(A_FLG, 32'h40);
		rdChk(A_FLG, 32'h00);
		chk(32'(irq), 32'h0);
		lastRes = fmt(analogIn, just);
		rdChk(A_RH, {24'h0, lastRes[15:8]});
		rdChk(A_RL, {24'h0, lastRes[7:0]});
	endtask

	task automatic startThenWait();
		waitHold();
		wr(A_ANS, 32'h0F);
		wr(A_CTL, 32'h01);
		wr(A_CTL, 32'h03);
		repeat (5) @(posedge clock);
	endtask

	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	initial begin
		#400us;
		numErrors++;
		endOfTest();
	end

	initial begin
		logic [31:0] q;
		logic        e;
		nrst = 1'b0;
		{psel, penable, pwrite, sleepIn} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		analogIn = 10'h0;
		void'($urandom(89));
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		rdChk(A_CTL, 32'h00);
		rdChk(A_ANS, 32'h0F);
		rdChk(A_EN, 32'h00);
		rdChk(A_FLG, 32'h00);
		apb(1'b0, 12'h004, 32'h0, q, e);
		chk(32'(e), 32'h1);
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			convert(3'(i), 1'($urandom), 1'b0);
		end
		convert(3'b111, 1'b0, 1'b0);
		$display("test clock selects done");
		convert(3'b011, 1'b1, 1'b1);
		convert(3'b111, 1'b0, 1'b1);
		$display("test sleep with rc clock done");
		startThenWait();
		sleepIn <= 1'b1;
		repeat (3) @(posedge clock);
		chk(32'(modulePowered), 32'h0);
		rdChk(A_CTL, 32'h01);
		sleepIn <= 1'b0;
		rdChk(A_FLG, 32'h00);
		rdChk(A_RH, {24'h0, lastRes[15:8]});
		$display("test sleep abort done");
		startThenWait();
		wr(A_CTL, 32'h01);
		rdChk(A_CTL, 32'h01);
		rdChk(A_FLG, 32'h00);
		rdChk(A_RL, {24'h0, lastRes[7:0]});
		$display("test software abort done");
		startThenWait();
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		chk(32'(modulePowered), 32'h0);
		nrst <= 1'b1;
		rdChk(A_CTL, 32'h00);
		rdChk(A_ANS, 32'h0F);
		rdChk(A_RH, {24'h0, lastRes[15:8]});
		rdChk(A_RL, {24'h0, lastRes[7:0]});
		$display("test reset mid conversion done");
		endOfTest();
	end
endmodule
